/* File: shunt_amp_ctrl_and_uv_faults.sv */
// Shunt amplifier sequencing and supply / gate-supply undervoltage fault logic
// Notes on behaviour
// [R1] Supply undervoltage: gates off, pump off, fault low
// [R2] Supply undervoltage latches global and supply flags
// [R3] Drive resumes; supply flag held until clear
// [R4] Gate-supply undervoltage: gates off, fault low
// [R5] Gate-supply undervoltage latches global and gate flags
// [R6] Drive resumes; gate flag held until clear
// [R7] Disable bit kills gate-supply protection; pin variant always
// [R8] Calibration bit shorts inputs, disconnects load
// [R9] Manual calibration accepted at any time
// [R10] Manual calibration only on serial variant
// [R11] Auto trim starts when reference becomes good
// [R12] Controller waits 50 us for power-up trim
// [R13] Calibration write reruns trim when auto-trim enabled
// [R14] All amplifiers at maximum gain during trim
// [R15] Gain chooses among four settings
// [R16] Reference divider removal gives unidirectional sensing
// [R17] Drop-sense routes positive input to switch node
// [R18] Drop-sense forces low-side reference to negative input
// [R19] Drop-sense amp enabled after drive timer ends
// [R20] Drop-sense shorts inputs when low-side commanded off
// [R21] Pin variant decodes four-level and seven-level inputs
// [R22] Fault output is open-drain, pull low only
// [R23] Clear by register bit or enable low pulse
// [R24] Fault output low while any undervoltage active; a gate-supply undervoltage with the disable bit set leaves it released
module shunt_amp_ctrl_and_uv_faults
    import amp_uv_pkg::*;
#(
    parameter bit SERIAL_VARIANT = 1'b1,
    parameter int TRIM_CYC = TRIM_CYCLES
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [7:0] rdata,
    input wire uv_inputs_t uv_in,
    input wire logic ref_good,
    input wire logic enable_pin,
    input wire logic [NUM_AMPS-1:0] lowside_on_cmd,
    input wire logic [NUM_AMPS-1:0] drive_timer_done,
    input wire level4_t gain_pin_level,
    input wire level4_t mode_pin_level,
    input wire logic [2:0] drive_current_select,
    input wire logic [2:0] drain_source_level_select,
    output logic gates_off,
    output logic charge_pump_off,
    output logic fault_out_n_o,
    output logic fault_out_n_oe_n,
    output amp_ctrl_t amp_ctrl,
    output logic [1:0] mode_sel,
    output logic [2:0] drive_current_level,
    output logic [2:0] drain_source_level
);
    // The counters and read-back packing are sized for these ranges only
    if (TRIM_CYC < 1 || TRIM_CYC > 65535) begin
        $error("TRIM_CYC out of range");
    end
    if (NUM_AMPS != 3 || RST_MAX_CYC >= 1023) begin
        $error("package constants do not fit the counters");
    end

    // Pin and analog comparator inputs come from outside the clock domain
    logic [3:0] uv_s1_r, uv_s2_r;
    logic ref_s1_r, ref_s2_r, en_s1_r, en_s2_r;
    logic [NUM_AMPS-1:0] ls_s1_r, ls_s2_r, dt_s1_r, dt_s2_r;
    logic [1:0] gain_s1_r, gain_s2_r, mode_s1_r, mode_s2_r;
    logic [2:0] idr_s1_r, idr_s2_r, vds_s1_r, vds_s2_r;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            uv_s1_r <= 4'h0;
            uv_s2_r <= 4'h0;
            ref_s1_r <= 1'b0;
            ref_s2_r <= 1'b0;
            en_s1_r <= 1'b1;
            en_s2_r <= 1'b1;
            ls_s1_r <= '0;
            ls_s2_r <= '0;
            dt_s1_r <= '0;
            dt_s2_r <= '0;
            gain_s1_r <= 2'h0;
            gain_s2_r <= 2'h0;
            mode_s1_r <= 2'h0;
            mode_s2_r <= 2'h0;
            idr_s1_r <= 3'h0;
            idr_s2_r <= 3'h0;
            vds_s1_r <= 3'h0;
            vds_s2_r <= 3'h0;
        end else begin
            uv_s1_r <= uv_in;
            uv_s2_r <= uv_s1_r;
            ref_s1_r <= ref_good;
            ref_s2_r <= ref_s1_r;
            en_s1_r <= enable_pin;
            en_s2_r <= en_s1_r;
            ls_s1_r <= lowside_on_cmd;
            ls_s2_r <= ls_s1_r;
            dt_s1_r <= drive_timer_done;
            dt_s2_r <= dt_s1_r;
            gain_s1_r <= gain_pin_level;
            gain_s2_r <= gain_s1_r;
            mode_s1_r <= mode_pin_level;
            mode_s2_r <= mode_s1_r;
            idr_s1_r <= drive_current_select;
            idr_s2_r <= idr_s1_r;
            vds_s1_r <= drain_source_level_select;
            vds_s2_r <= vds_s1_r;
        end
    end

    uv_inputs_t uv_sync;
    assign uv_sync = uv_s2_r;

    // Register file
    logic [7:0] ctrl_r;
    logic [NUM_AMPS-1:0] cal_r;
    logic supply_uv_flag_r, gate_supply_uv_flag_r;
    logic trim_busy_r;
    logic clear_faults_bit;
    logic cal_write;
    assign clear_faults_bit = SERIAL_VARIANT && wr_en && addr == ADDR_CTRL
        && wdata[CTRL_CLEAR_FAULTS];
    assign cal_write = SERIAL_VARIANT && wr_en && addr == ADDR_CAL; // [R10]

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_r <= CTRL_RESET;
        end else if (SERIAL_VARIANT && wr_en && addr == ADDR_CTRL) begin
            ctrl_r <= {wdata[7:1], 1'b0};
        end
    end

    // Calibration bits accepted regardless of switching state
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cal_r <= '0;
        end else if (cal_write) begin
            cal_r <= wdata[NUM_AMPS-1:0]; // [R9] [R10]
        end
    end

    // Enable low pulse of the reset width clears faults on its rising edge
    logic [9:0] en_low_cnt_r;
    logic en_pulse_clear;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            en_low_cnt_r <= 10'h000;
        end else if (!en_s2_r) begin
            if (en_low_cnt_r != 10'h3FF) begin
                en_low_cnt_r <= en_low_cnt_r + 10'h001;
            end
        end else begin
            en_low_cnt_r <= 10'h000;
        end
    end
    assign en_pulse_clear = en_s2_r && en_low_cnt_r >= 10'(RST_MIN_CYC)
        && en_low_cnt_r <= 10'(RST_MAX_CYC);
    logic clear_any;
    assign clear_any = clear_faults_bit || en_pulse_clear; // [R23]

    logic gate_uv_protect_off;
    assign gate_uv_protect_off = SERIAL_VARIANT && ctrl_r[CTRL_GATE_UV_OFF]; // [R7]
    logic supply_uv_now, gate_uv_now;
    assign supply_uv_now = uv_sync.motor_supply_uv || uv_sync.drain_sense_supply_uv;
    assign gate_uv_now = !gate_uv_protect_off
        && (uv_sync.charge_pump_output_uv || uv_sync.lowside_gate_supply_uv); // [R7]

    // Set wins over clear so an event in the clearing cycle is kept
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            supply_uv_flag_r <= 1'b0;
        end else if (supply_uv_now) begin
            supply_uv_flag_r <= 1'b1; // [R2]
        end else if (clear_any) begin
            supply_uv_flag_r <= 1'b0; // [R3]
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            gate_supply_uv_flag_r <= 1'b0;
        end else if (gate_uv_now) begin
            gate_supply_uv_flag_r <= 1'b1; // [R5]
        end else if (clear_any) begin
            gate_supply_uv_flag_r <= 1'b0; // [R6]
        end
    end

    // Protective action follows live conditions, so drive resumes unaided
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            gates_off <= 1'b1;
            charge_pump_off <= 1'b1;
            fault_out_n_o <= 1'b0;
            fault_out_n_oe_n <= 1'b1;
        end else begin
            gates_off <= supply_uv_now || gate_uv_now; // [R1] [R4] [R3] [R6]
            charge_pump_off <= supply_uv_now; // [R1]
            fault_out_n_o <= 1'b0; // [R22]
            fault_out_n_oe_n <= !(supply_uv_now || gate_uv_now); // [R24] [R22]
        end
    end

    // Trim sequencer
    typedef enum logic [1:0] {TRIM_WAIT_REF, TRIM_RUN, TRIM_IDLE} trim_state_t;
    trim_state_t trim_state_r;
    logic [15:0] trim_cnt_r;
    logic rerun_req;
    assign rerun_req = cal_write && ctrl_r[CTRL_AUTO_TRIM_EN] && wdata[NUM_AMPS-1:0] != '0;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            trim_state_r <= TRIM_WAIT_REF;
            trim_cnt_r <= 16'h0000;
        end else begin
            unique case (trim_state_r)
                TRIM_WAIT_REF: begin
                    if (ref_s2_r) begin
                        trim_state_r <= TRIM_RUN; // [R11]
                        trim_cnt_r <= 16'h0000;
                    end
                end
                TRIM_RUN: begin
                    if (trim_cnt_r == 16'(TRIM_CYC - 1)) begin
                        trim_state_r <= TRIM_IDLE; // [R12]
                    end else begin
                        trim_cnt_r <= trim_cnt_r + 16'h0001;
                    end
                end
                TRIM_IDLE: begin
                    if (rerun_req) begin
                        trim_state_r <= TRIM_RUN; // [R13]
                        trim_cnt_r <= 16'h0000;
                    end
                end
                default: begin
                    trim_state_r <= TRIM_WAIT_REF;
                end
            endcase
        end
    end
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            trim_busy_r <= 1'b0;
        end else begin
            trim_busy_r <= trim_state_r == TRIM_RUN;
        end
    end

    // Amplifier control, including drop-sense sequencing per phase
    logic [1:0] gain_cfg;
    assign gain_cfg = SERIAL_VARIANT ? ctrl_r[CTRL_GAIN_LSB +: 2] : gain_s2_r; // [R15]
    logic fet_drop_sense_enable;
    assign fet_drop_sense_enable = SERIAL_VARIANT && ctrl_r[CTRL_FET_SENSE];
    logic manual_cal;
    assign manual_cal = !ctrl_r[CTRL_AUTO_TRIM_EN];
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            amp_ctrl <= '0;
        end else begin
            for (int i = 0; i < NUM_AMPS; i++) begin
                amp_ctrl.load_off[i] <= manual_cal && cal_r[i]; // [R8]
                amp_ctrl.cal_short[i] <= (manual_cal && cal_r[i])
                    || (fet_drop_sense_enable && !ls_s2_r[i]); // [R8] [R20]
                amp_ctrl.pos_to_switch_node[i] <= fet_drop_sense_enable; // [R17]
                amp_ctrl.amp_enable[i] <= !fet_drop_sense_enable
                    || (ls_s2_r[i] && dt_s2_r[i]); // [R19]
            end
            amp_ctrl.lowside_monitor_ref_select_is_neg <= fet_drop_sense_enable
                || (SERIAL_VARIANT && ctrl_r[CTRL_LOWSIDE_MONITOR_REF_SELECT_SEL]); // [R18]
            amp_ctrl.ref_div_off <= SERIAL_VARIANT && ctrl_r[CTRL_REF_DIV_OFF]; // [R16]
            amp_ctrl.gain_sel <= (trim_state_r == TRIM_RUN) ? GAIN_MAX : gain_cfg; // [R14] [R15]
        end
    end

    // Pin-variant level decode; seven-level pins arrive as codes 0..7, code 7 read as 6
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mode_sel <= 2'h0;
            drive_current_level <= 3'h0;
            drain_source_level <= 3'h0;
        end else begin
            mode_sel <= mode_s2_r; // [R21]
            drive_current_level <= (idr_s2_r == 3'h7) ? 3'h6 : idr_s2_r; // [R21]
            drain_source_level <= (vds_s2_r == 3'h7) ? 3'h6 : vds_s2_r; // [R21]
        end
    end

    // Read port, data one cycle after the strobe; unmapped reads zero
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata <= 8'h00;
        end else if (rd_en) begin
            unique case (addr)
                ADDR_CTRL: rdata <= ctrl_r;
                ADDR_CAL: rdata <= {5'h00, cal_r};
                ADDR_STATUS: rdata <= {3'h0, !fault_out_n_oe_n, trim_busy_r,
                    gate_supply_uv_flag_r, supply_uv_flag_r,
                    supply_uv_flag_r || gate_supply_uv_flag_r}; // [R2] [R5]
                ADDR_CFG: rdata <= {7'h00, SERIAL_VARIANT};
                default: rdata <= 8'h00;
            endcase
        end else begin
            rdata <= 8'h00;
        end
    end

    // Checks watch the registered outputs one edge after the cause
    AST_SUPPLY_FLAG: assert property (@(posedge clk) disable iff (!arst_n) // [R2]
        supply_uv_now |=> supply_uv_flag_r)
        else $error("supply flag not set");
    AST_SUPPLY_HOLD: assert property (@(posedge clk) disable iff (!arst_n) // [R3]
        supply_uv_flag_r && !clear_any |=> supply_uv_flag_r)
        else $error("supply flag lost");
    AST_GATE_FLAG: assert property (@(posedge clk) disable iff (!arst_n) // [R5]
        gate_uv_now |=> gate_supply_uv_flag_r && gates_off)
        else $error("gate flag not set");
    AST_GATE_HOLD: assert property (@(posedge clk) disable iff (!arst_n) // [R6]
        gate_supply_uv_flag_r && !clear_any |=> gate_supply_uv_flag_r)
        else $error("gate flag lost");
    AST_GATE_PIN: assert property (@(posedge clk) disable iff (!arst_n) // [R4]
        gate_uv_now |=> !fault_out_n_oe_n)
        else $error("gate uv not reported on pin");
    AST_GATE_OFF: assert property (@(posedge clk) disable iff (!arst_n) // [R7]
        gate_uv_protect_off && !supply_uv_now |=> !gates_off)
        else $error("gate protection active while disabled");
    AST_DISABLE_FLAG: assert property (@(posedge clk) disable iff (!arst_n) // [R7]
        gate_uv_protect_off && !gate_supply_uv_flag_r |=> !gate_supply_uv_flag_r)
        else $error("gate flag set while disabled");
    AST_CLEAR: assert property (@(posedge clk) disable iff (!arst_n) // [R23]
        clear_any && !supply_uv_now && !gate_uv_now
        |=> !supply_uv_flag_r && !gate_supply_uv_flag_r)
        else $error("flags not cleared");
    AST_PUMP_OFF: assert property (@(posedge clk) disable iff (!arst_n) // [R1]
        supply_uv_now |=> charge_pump_off && gates_off && !fault_out_n_oe_n)
        else $error("supply uv not acted on");
    AST_RESUME: assert property (@(posedge clk) disable iff (!arst_n) // [R24]
        !supply_uv_now && !gate_uv_now |=> fault_out_n_oe_n && !gates_off)
        else $error("no resume");
    AST_MAXGAIN: assert property (@(posedge clk) disable iff (!arst_n) // [R14]
        trim_state_r == TRIM_RUN |=> amp_ctrl.gain_sel == GAIN_MAX)
        else $error("gain not max in trim");
    AST_GAIN_CFG: assert property (@(posedge clk) disable iff (!arst_n) // [R15]
        trim_state_r != TRIM_RUN |=> amp_ctrl.gain_sel == $past(gain_cfg))
        else $error("gain not as configured");
    AST_TRIM_START: assert property (@(posedge clk) disable iff (!arst_n) // [R11]
        trim_state_r == TRIM_WAIT_REF && ref_s2_r |=> trim_state_r == TRIM_RUN)
        else $error("trim not started");
    AST_CAL_MODE: assert property (@(posedge clk) disable iff (!arst_n) // [R8]
        manual_cal |=> amp_ctrl.load_off == $past(cal_r)
        && (amp_ctrl.cal_short & $past(cal_r)) == $past(cal_r))
        else $error("calibration mode not applied");
    AST_REF_DIV: assert property (@(posedge clk) disable iff (!arst_n) // [R16]
        SERIAL_VARIANT && ctrl_r[CTRL_REF_DIV_OFF] |=> amp_ctrl.ref_div_off)
        else $error("reference divider not removed");
    AST_DROP_ROUTE: assert property (@(posedge clk) disable iff (!arst_n) // [R17] [R19]
        fet_drop_sense_enable |=> amp_ctrl.pos_to_switch_node == '1
        && amp_ctrl.amp_enable == ($past(ls_s2_r) & $past(dt_s2_r)))
        else $error("drop-sense routing wrong");
    AST_DROP_SHORT: assert property (@(posedge clk) disable iff (!arst_n) // [R20]
        fet_drop_sense_enable |=> (amp_ctrl.cal_short | $past(ls_s2_r)) == '1)
        else $error("off phase not shorted");
    AST_LSREF: assert property (@(posedge clk) disable iff (!arst_n) // [R18]
        fet_drop_sense_enable |=> amp_ctrl.lowside_monitor_ref_select_is_neg)
        else $error("low-side ref not forced");
    AST_OD: assert property (@(posedge clk) disable iff (!arst_n) // [R22]
        $past(arst_n) |-> !fault_out_n_o)
        else $error("fault pin driven high");
    COV_UV: cover property (@(posedge clk) disable iff (!arst_n) supply_uv_now);
    COV_GATE_SUPPLY_UV_FLAG: cover property (@(posedge clk) disable iff (!arst_n) gate_uv_now);
    COV_RERUN: cover property (@(posedge clk) disable iff (!arst_n) rerun_req);
    COV_PULSE: cover property (@(posedge clk) disable iff (!arst_n) en_pulse_clear);
    COV_DROP: cover property (@(posedge clk) disable iff (!arst_n)
        fet_drop_sense_enable && dt_s2_r != '0);
endmodule

/* File: amp_uv_pkg.sv */
// Package for the shunt amplifier control and undervoltage fault block
package amp_uv_pkg;
    localparam int NUM_AMPS = 3;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_CAL = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_CFG = 8'h0C;
    localparam int CTRL_CLEAR_FAULTS = 0;
    localparam int CTRL_GATE_UV_OFF = 1;
    localparam int CTRL_AUTO_TRIM_EN = 2;
    localparam int CTRL_REF_DIV_OFF = 3;
    localparam int CTRL_FET_SENSE = 4;
    localparam int CTRL_LOWSIDE_MONITOR_REF_SELECT_SEL = 5;
    localparam int CTRL_GAIN_LSB = 6;
    localparam int ST_FAULT = 0;
    localparam int ST_SUPPLY_UV = 1;
    localparam int ST_GATE_UV = 2;
    localparam int ST_TRIM_BUSY = 3;
    localparam int ST_FAULT_OUT = 4;
    localparam logic [1:0] GAIN_MAX = 2'h3;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam int CLK_HZ = 10_000_000;
    localparam int TRIM_TIME_US = 50;
    localparam int TRIM_CYCLES = TRIM_TIME_US * (CLK_HZ / 1_000_000);
    localparam int RST_PULSE_MIN_US = 8;
    localparam int RST_PULSE_MAX_US = 40;
    localparam int RST_MIN_CYC = RST_PULSE_MIN_US * (CLK_HZ / 1_000_000);
    localparam int RST_MAX_CYC = RST_PULSE_MAX_US * (CLK_HZ / 1_000_000);
    typedef struct packed {
        logic motor_supply_uv;
        logic drain_sense_supply_uv;
        logic charge_pump_output_uv;
        logic lowside_gate_supply_uv;
    } uv_inputs_t;
    typedef struct packed {
        logic [NUM_AMPS-1:0] cal_short;
        logic [NUM_AMPS-1:0] load_off;
        logic [NUM_AMPS-1:0] pos_to_switch_node;
        logic [NUM_AMPS-1:0] amp_enable;
        logic lowside_monitor_ref_select_is_neg;
        logic ref_div_off;
        logic [1:0] gain_sel;
    } amp_ctrl_t;
    typedef enum logic [1:0] {
        HW_LEVEL_ZERO,
        HW_LEVEL_ONE,
        HW_LEVEL_TWO,
        HW_LEVEL_THREE
    } level4_t;
endpackage

/* File: motor_ctrl_model.sv */
// Behavioural model of the external motor controller on the pin side
module motor_ctrl_model #(
    parameter int PULSE_CYC = 200
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic pulse_go,
    input wire logic fault_out_n_o,
    input wire logic fault_out_n_oe_n,
    output logic enable_pin,
    output logic fault_pin
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt;
    // Board pullup wins whenever the device lets go of the pin
    assign fault_pin = fault_out_n_oe_n ? 1'b1 : fault_out_n_o;
    // Low pulse inside the 8..40 us window; fixed length keeps it in the middle
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt <= 0;
            enable_pin <= 1'b1;
        end else if (pulse_go && cnt == 0) begin
            cnt <= PULSE_CYC;
            enable_pin <= 1'b0;
        end else if (cnt > 1) begin
            cnt <= cnt - 1;
        end else begin
            cnt <= 0;
            enable_pin <= 1'b1;
        end
    end
endmodule

/* File: tb_shunt_amp_ctrl_and_uv_faults.sv */
// Testbench for the shunt amplifier control and undervoltage fault block
module tb_shunt_amp_ctrl_and_uv_faults
    import amp_uv_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int TRIM_SIM = 20;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [7:0] rdata;
    uv_inputs_t uv_in = '0;
    logic ref_good = 1'b0;
    logic enable_pin;
    logic pulse_go = 1'b0;
    logic fault_pin;
    logic [NUM_AMPS-1:0] lowside_on_cmd = '0;
    logic [NUM_AMPS-1:0] drive_timer_done = '0;
    level4_t gain_pin_level = HW_LEVEL_ZERO;
    level4_t mode_pin_level = HW_LEVEL_ZERO;
    logic [2:0] drive_current_select = 3'h0;
    logic [2:0] drain_source_level_select = 3'h0;
    logic gates_off;
    logic charge_pump_off;
    logic fault_out_n_o;
    logic fault_out_n_oe_n;
    amp_ctrl_t amp_ctrl;
    logic [1:0] mode_sel;
    logic [2:0] drive_current_level;
    logic [2:0] drain_source_level;
    int miscompares = 0;
    int tests_run = 0;
    logic [7:0] d;
    always #50 clk = ~clk;
    shunt_amp_ctrl_and_uv_faults #(.SERIAL_VARIANT(1'b1), .TRIM_CYC(TRIM_SIM)) dut_u (
        .clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
        .rd_en(rd_en), .rdata(rdata), .uv_in(uv_in), .ref_good(ref_good),
        .enable_pin(enable_pin), .lowside_on_cmd(lowside_on_cmd),
        .drive_timer_done(drive_timer_done), .gain_pin_level(gain_pin_level),
        .mode_pin_level(mode_pin_level), .drive_current_select(drive_current_select),
        .drain_source_level_select(drain_source_level_select), .gates_off(gates_off),
        .charge_pump_off(charge_pump_off), .fault_out_n_o(fault_out_n_o),
        .fault_out_n_oe_n(fault_out_n_oe_n), .amp_ctrl(amp_ctrl), .mode_sel(mode_sel),
        .drive_current_level(drive_current_level), .drain_source_level(drain_source_level));
    motor_ctrl_model #(.PULSE_CYC(200)) ctrl_u (
        .clk(clk), .arst_n(arst_n), .pulse_go(pulse_go), .fault_out_n_o(fault_out_n_o),
        .fault_out_n_oe_n(fault_out_n_oe_n), .enable_pin(enable_pin), .fault_pin(fault_pin));
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask
    // Read data only stand in the cycle after the strobe, so sample there
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        d = rdata;
    endtask
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        report_and_stop();
    end
    initial begin
        logic sup;
        int k;
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        ref_good <= 1'b1;
        cyc(4);
        chk("trim gain", 8'(GAIN_MAX), 8'(amp_ctrl.gain_sel));
        rd(ADDR_STATUS);
        chk("trim busy", 8'h08, d & 8'h08);
        k = 0;
        // Controller allows the power-up trim to finish before using outputs
        while (d[ST_TRIM_BUSY] !== 1'b0 && k < 100) begin
            rd(ADDR_STATUS);
            k++;
        end
        chk("trim done", 8'h00, d);
        // Each undervoltage source; clear alternates between bit and enable pulse
        for (int i = 0; i < 4; i++) begin
            sup = (i < 2);
            uv_in <= uv_inputs_t'(4'h8 >> i);
            cyc(4);
            chk("gates off", 8'h01, 8'(gates_off));
            chk("pump off", 8'(sup), 8'(charge_pump_off));
            chk("fault pin", 8'h00, 8'(fault_pin));
            rd(ADDR_STATUS);
            chk("uv status", sup ? 8'h13 : 8'h15, d);
            uv_in <= '0;
            cyc(4);
            chk("gates back", 8'h00, 8'(gates_off));
            chk("pin back", 8'h01, 8'(fault_pin));
            rd(ADDR_STATUS);
            chk("flag held", sup ? 8'h03 : 8'h05, d);
            if (i % 2 == 0) begin
                wr(ADDR_CTRL, 8'h01);
            end else begin
                @(posedge clk);
                pulse_go <= 1'b1;
                @(posedge clk);
                pulse_go <= 1'b0;
                cyc(210);
            end
            cyc(2);
            rd(ADDR_STATUS);
            chk("cleared", 8'h00, d);
        end
        wr(ADDR_CTRL, 8'h02);
        uv_in <= uv_inputs_t'(4'h1);
        cyc(4);
        chk("gate uv off", 8'h00, 8'(gates_off));
        chk("gate uv off pin", 8'h01, 8'(fault_pin));
        rd(ADDR_STATUS);
        chk("gate uv off st", 8'h00, d);
        uv_in <= '0;
        // Calibration requested while low sides are off keeps noise down
        wr(ADDR_CTRL, 8'h00);
        wr(ADDR_CAL, 8'h05);
        cyc(2);
        chk("cal short", 8'h05, 8'(amp_ctrl.cal_short));
        chk("load off", 8'h05, 8'(amp_ctrl.load_off));
        wr(ADDR_CAL, 8'h00);
        wr(ADDR_CTRL, 8'h44);
        wr(ADDR_CAL, 8'h02);
        cyc(2);
        chk("rerun gain", 8'(GAIN_MAX), 8'(amp_ctrl.gain_sel));
        rd(ADDR_STATUS);
        chk("rerun busy", 8'h08, d);
        cyc(TRIM_SIM + 10);
        chk("gain back", 8'h01, 8'(amp_ctrl.gain_sel));
        wr(ADDR_CAL, 8'h00);
        for (int g = 0; g < 4; g++) begin
            wr(ADDR_CTRL, 8'((g << CTRL_GAIN_LSB) | 8'h08));
            rd(ADDR_CTRL);
            chk("ctrl back", 8'((g << CTRL_GAIN_LSB) | 8'h08), d);
            chk("gain sel", 8'(g), 8'(amp_ctrl.gain_sel));
            chk("ref div", 8'h01, 8'(amp_ctrl.ref_div_off));
            chk("lowside_monitor_ref_select off", 8'h00, 8'(amp_ctrl.lowside_monitor_ref_select_is_neg));
        end
        wr(ADDR_CTRL, 8'h20);
        cyc(2);
        chk("lowside_monitor_ref_select sel", 8'h01, 8'(amp_ctrl.lowside_monitor_ref_select_is_neg));
        wr(ADDR_CTRL, 8'h10);
        lowside_on_cmd <= 3'b011;
        drive_timer_done <= 3'b001;
        cyc(5);
        chk("pos to node", 8'h07, 8'(amp_ctrl.pos_to_switch_node));
        chk("lowside_monitor_ref_select neg", 8'h01, 8'(amp_ctrl.lowside_monitor_ref_select_is_neg));
        chk("amp enable", 8'h01, 8'(amp_ctrl.amp_enable));
        chk("off short", 8'h04, 8'(amp_ctrl.cal_short));
        wr(ADDR_CTRL, 8'h00);
        lowside_on_cmd <= 3'b110;
        wr(ADDR_CAL, 8'h03);
        cyc(2);
        chk("cal while on", 8'h03, 8'(amp_ctrl.load_off));
        mode_pin_level <= HW_LEVEL_TWO;
        gain_pin_level <= HW_LEVEL_ONE;
        drive_current_select <= 3'h7;
        drain_source_level_select <= 3'h3;
        cyc(5);
        chk("mode sel", 8'h02, 8'(mode_sel));
        chk("drive lvl", 8'h06, 8'(drive_current_level));
        chk("vds lvl", 8'h03, 8'(drain_source_level));
        rd(8'h10);
        chk("unmapped", 8'h00, d);
        rd(ADDR_CFG);
        chk("variant", 8'h01, d);
        report_and_stop();
    end
endmodule
